// ==== hw/ivg_top.sv ====
// module: interrupt vector address generator with apb registers
//
// Local design decisions: register access over APB and the address map.
`timescale 1ns/1ps
//
// Notes on behaviour
// RQ1: fixed slots lie in FFFDC..FFFFF, never relocated
// RQ2: each slot is four bytes, routine start
// RQ3: undefined-opcode trap fetches from FFFDC
// RQ4: overflow trap fetches from FFFE0
// RQ5: break reads FFFE4; all ones uses table slot 0
// RQ6: address match uses FFFE8, gated by enable
// RQ7: watchdog FFFF0, nmi FFFF8, reset FFFFC
// RQ8: single-step and debugger slots for debugging only
// RQ9: table is 256 bytes from software base
// RQ10: slot address is base plus four times number
// RQ11: table slot 0 serves break, not maskable
// RQ12: slots 4..10: pin3, timers, shared slot 10
// RQ13: slots 11..14: dma0, dma1, key, a-d
// RQ14: slots 15..20: serial 2, 0, 1 tx/rx
// RQ15: slots 21..28: timers, shared 24 and 25
// RQ16: slots 29..31: pin interrupts 0, 1, 2
// RQ17: slots 32..63 software only, not maskable
// RQ18: select bit 4 picks slot 10 source
// RQ19: select bits 6, 7 pick slots 24, 25
// RQ20: software fills fixed slots before use
// RQ21: software numbers 0..31 share peripheral slots
// RQ22: four bytes, low first, keep twenty bits
//
module ivg_top (
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // request from the interrupt sequencer
    input wire logic req_valid,
    input wire ivg_pkg::ivg_kind_type req_kind,
    input wire logic [5:0] req_num,
    input wire logic i_flag,
    output logic req_busy,
    output logic req_err,
    // answer to the interrupt sequencer
    output logic vec_valid,
    output logic [19:0] vec_addr,
    output logic [19:0] vec_slot,
    // memory byte port
    output logic mem_req,
    output logic [19:0] mem_addr,
    input wire logic mem_ack,
    input wire logic [7:0] mem_rdata
);
    // ****************************************
    // state
    // ****************************************
    typedef enum logic [1:0] {S_IDLE, S_FETCH, S_BRK2} ivg_st_type;

    typedef struct packed {
        ivg_st_type st;
        logic [19:0] base;
        logic [7:0] sel_a;
        logic [7:0] sel_b;
        logic am_en;
        logic busy;
        logic break_instruction;
        logic [19:0] slot;
        logic [19:0] vec;
        logic vec_v;
        logic err;
        logic start;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } ivg_top_state_type;

    ivg_top_state_type s_r, s_nxt;
    ivg_fetch_if fif ();
    logic [19:0] calc_slot;
    logic calc_ok;
    logic acc;
    logic refuse;
    logic apb_wr;
    logic apb_acc;

    // ****************************************
    // sub-blocks
    // ****************************************
    ivg_slot_calc u_calc (
        .kind(req_kind),
        .num(req_num),
        .base(s_r.base),
        .sel_a(s_r.sel_a),
        .sel_b(s_r.sel_b),
        .slot(calc_slot),
        .ok(calc_ok)
    );

    ivg_fetch_eng u_eng (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .f(fif.eng),
        .mem_req(mem_req),
        .mem_addr(mem_addr),
        .mem_ack(mem_ack),
        .mem_rdata(mem_rdata)
    );

    // request take-over and refusal conditions
    assign acc = req_valid && !s_r.busy;
    assign refuse = !calc_ok
        || (req_kind == ivg_pkg::K_FIXED && req_num == ivg_pkg::FX_AMATCH && !s_r.am_en) // RQ6
        || (req_kind == ivg_pkg::K_PERIPH && !i_flag); // RQ11 RQ17
    assign apb_acc = psel && penable && s_r.pready;
    assign apb_wr = apb_acc && pwrite;

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        s_nxt = s_r;
        s_nxt.vec_v = 1'b0;
        s_nxt.err = 1'b0;
        s_nxt.start = 1'b0;
        // apb: one wait cycle, then the access completes
        s_nxt.pready = psel && penable && !s_r.pready;
        s_nxt.pslverr = 1'b0;
        s_nxt.prdata = 32'h00000000;
        if (psel && penable && !s_r.pready) begin
            case (paddr)
                ivg_pkg::REG_BASE: s_nxt.prdata = {12'h000, s_r.base}; // RQ9
                ivg_pkg::REG_CTRL: s_nxt.prdata = {31'h00000000, s_r.am_en};
                ivg_pkg::REG_STAT: s_nxt.prdata = {29'h00000000, s_r.break_instruction, s_r.st == S_FETCH, s_r.busy};
                ivg_pkg::REG_SLOT: s_nxt.prdata = {12'h000, s_r.slot};
                ivg_pkg::REG_VEC: s_nxt.prdata = {12'h000, s_r.vec};
                {ivg_pkg::IDX_SEL_A[9:0], 2'b00}: s_nxt.prdata = {24'h000000, s_r.sel_a};
                {ivg_pkg::IDX_SEL_B[9:0], 2'b00}: s_nxt.prdata = {24'h000000, s_r.sel_b};
                default: s_nxt.pslverr = 1'b1;
            endcase
        end
        // register writes take effect at the completing edge
        if (apb_wr) begin
            case (paddr)
                ivg_pkg::REG_BASE: s_nxt.base = pwdata[19:0]; // RQ9
                ivg_pkg::REG_CTRL: s_nxt.am_en = pwdata[ivg_pkg::CTRL_AMATCH_BIT];
                {ivg_pkg::IDX_SEL_A[9:0], 2'b00}: s_nxt.sel_a = pwdata[7:0]; // RQ18
                {ivg_pkg::IDX_SEL_B[9:0], 2'b00}: s_nxt.sel_b = pwdata[7:0]; // RQ19
                default: s_nxt.base = s_r.base;
            endcase
        end
        // vector sequencing
        case (s_r.st)
            S_IDLE: begin
                if (acc && refuse) begin
                    s_nxt.err = 1'b1;
                end else if (acc) begin
                    s_nxt.busy = 1'b1;
                    s_nxt.start = 1'b1;
                    s_nxt.slot = calc_slot; // RQ1 RQ3 RQ4 RQ7 RQ10 RQ21
                    s_nxt.break_instruction = (req_kind == ivg_pkg::K_FIXED) && (req_num == ivg_pkg::FX_BRK);
                    s_nxt.st = S_FETCH;
                end
            end
            S_FETCH: begin
                if (fif.done && s_r.break_instruction && fif.word == ivg_pkg::BRK_ERASED) begin
                    s_nxt.start = 1'b1;
                    s_nxt.slot = s_r.base; // RQ5 RQ11
                    s_nxt.st = S_BRK2;
                end else if (fif.done) begin
                    s_nxt.vec = fif.word[19:0]; // RQ22
                    s_nxt.vec_v = 1'b1;
                    s_nxt.busy = 1'b0;
                    s_nxt.break_instruction = 1'b0;
                    s_nxt.st = S_IDLE;
                end
            end
            S_BRK2: begin
                if (fif.done) begin
                    s_nxt.vec = fif.word[19:0]; // RQ22
                    s_nxt.vec_v = 1'b1;
                    s_nxt.busy = 1'b0;
                    s_nxt.break_instruction = 1'b0;
                    s_nxt.st = S_IDLE;
                end
            end
            default: begin
                s_nxt.st = S_IDLE;
                s_nxt.busy = 1'b0;
            end
        endcase
    end

    // state register
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign fif.start = s_r.start;
    assign fif.addr = s_r.slot;
    assign prdata = s_r.prdata;
    assign pready = s_r.pready;
    assign pslverr = s_r.pslverr;
    assign req_busy = s_r.busy;
    assign req_err = s_r.err;
    assign vec_valid = s_r.vec_v;
    assign vec_addr = s_r.vec;
    assign vec_slot = s_r.slot;

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    sequence q_take_fixed(logic [5:0] idx);
        acc && !refuse && req_kind == ivg_pkg::K_FIXED && req_num == idx;
    endsequence

    property p_fixed_rng;
        (s_r.st == S_FETCH && !s_r.break_instruction && $past(req_kind) == ivg_pkg::K_FIXED && $rose(s_r.busy))
            |-> s_r.slot >= ivg_pkg::FIXED_LO && s_r.slot + ivg_pkg::SLOT_LAST_BYTE <= ivg_pkg::FIXED_HI;
    endproperty
    a_fixed_rng: assert property (p_fixed_rng) else $error("fixed slot out of range"); // RQ1

    property p_und;
        q_take_fixed(ivg_pkg::FX_UND) |=> s_r.slot == ivg_pkg::VEC_UND ##1 mem_req && mem_addr == ivg_pkg::VEC_UND;
    endproperty
    a_und: assert property (p_und) else $error("undefined-opcode slot wrong"); // RQ3

    property p_ovf;
        q_take_fixed(ivg_pkg::FX_OVF) |=> s_r.slot == ivg_pkg::VEC_OVF;
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow slot wrong"); // RQ4

    property p_brk2;
        (s_r.st == S_FETCH && s_r.break_instruction && fif.done && fif.word == ivg_pkg::BRK_ERASED)
            |=> s_r.st == S_BRK2 && s_r.slot == s_r.base ##1 mem_addr == s_r.base;
    endproperty
    a_brk2: assert property (p_brk2) else $error("break fallback not taken"); // RQ5

    property p_amatch;
        (acc && req_kind == ivg_pkg::K_FIXED && req_num == ivg_pkg::FX_AMATCH && !s_r.am_en)
            |=> req_err && !req_busy;
    endproperty
    a_amatch: assert property (p_amatch) else $error("disabled address match not refused"); // RQ6

    property p_wdt_nmi;
        (q_take_fixed(ivg_pkg::FX_WDT) |=> s_r.slot == ivg_pkg::VEC_WDT)
            and (q_take_fixed(ivg_pkg::FX_NMI) |=> s_r.slot == ivg_pkg::VEC_NMI);
    endproperty
    a_wdt_nmi: assert property (p_wdt_nmi) else $error("watchdog or nmi slot wrong"); // RQ7

    property p_table;
        (acc && !refuse && req_kind == ivg_pkg::K_SWINT)
            |=> s_r.slot == s_r.base + {12'h000, $past(req_num), 2'b00}
                && s_r.slot - s_r.base <= ivg_pkg::TABLE_LAST_BYTE;
    endproperty
    a_table: assert property (p_table) else $error("table slot wrong"); // RQ10

    property p_nomask;
        (acc && req_kind == ivg_pkg::K_SWINT && !i_flag) |=> !req_err && req_busy;
    endproperty
    a_nomask: assert property (p_nomask) else $error("software number masked"); // RQ17

    property p_shared;
        (acc && req_kind == ivg_pkg::K_PERIPH && i_flag && req_num == ivg_pkg::SLOT_TA5
            && s_r.sel_a[ivg_pkg::SEL_A_BIT]) |=> req_err;
    endproperty
    a_shared: assert property (p_shared) else $error("deselected source took slot 10"); // RQ18

    property p_vec;
        (s_r.st != S_IDLE && fif.done && !(s_r.st == S_FETCH && s_r.break_instruction && fif.word == ivg_pkg::BRK_ERASED))
            |=> vec_valid && vec_addr == $past(fif.word[19:0]) ##1 !vec_valid;
    endproperty
    a_vec: assert property (p_vec) else $error("vector not delivered"); // RQ22
endmodule

// ==== hw/ivg_pkg.sv ====
// package: constants and types of the interrupt vector address generator
package ivg_pkg;

    // ****************************************
    // address space and vector slots
    // ****************************************
    localparam int ADDR_W = 20;
    localparam logic [19:0] FIXED_LO = 20'hfffdc;
    localparam logic [19:0] FIXED_HI = 20'hfffff;
    localparam logic [19:0] SLOT_LAST_BYTE = 20'h00003; // a slot spans four bytes
    localparam logic [19:0] TABLE_LAST_BYTE = 20'h000ff; // table spans 256 bytes
    localparam logic [19:0] VEC_UND = 20'hfffdc;
    localparam logic [19:0] VEC_OVF = 20'hfffe0;
    localparam logic [19:0] VEC_BRK = 20'hfffe4;
    localparam logic [19:0] VEC_AMATCH = 20'hfffe8;
    localparam logic [19:0] VEC_SSTEP = 20'hfffec;
    localparam logic [19:0] VEC_WDT = 20'hffff0;
    localparam logic [19:0] VEC_DBG = 20'hffff4;
    localparam logic [19:0] VEC_NMI = 20'hffff8;
    localparam logic [19:0] VEC_RST = 20'hffffc;
    localparam logic [31:0] BRK_ERASED = 32'hffffffff;

    // ****************************************
    // fixed slot index, request kinds
    // ****************************************
    localparam logic [5:0] FX_UND = 6'h00;
    localparam logic [5:0] FX_OVF = 6'h01;
    localparam logic [5:0] FX_BRK = 6'h02;
    localparam logic [5:0] FX_AMATCH = 6'h03;
    localparam logic [5:0] FX_WDT = 6'h05;
    localparam logic [5:0] FX_NMI = 6'h07;
    localparam logic [5:0] FX_LAST = 6'h08;
    typedef enum logic [1:0] {K_FIXED, K_SWINT, K_PERIPH} ivg_kind_type;

    // ****************************************
    // peripheral source ids and shared slots
    // ****************************************
    localparam logic [5:0] PID_BUSCOL = 6'h01;
    localparam logic [5:0] PID_EXT_PIN_IRQ_4 = 6'h02;
    localparam logic [5:0] PID_EXT_PIN_IRQ_5 = 6'h03;
    localparam logic [5:0] PID_FIRST = 6'h04;
    localparam logic [5:0] PID_LAST = 6'h1f;
    localparam logic [5:0] SLOT_TA5 = 6'h0a;
    localparam logic [5:0] SLOT_TA3 = 6'h18;
    localparam logic [5:0] SLOT_TA4 = 6'h19;
    localparam int SEL_A_BIT = 4;
    localparam int SEL_B_TA3_BIT = 6;
    localparam int SEL_B_TA4_BIT = 7;

    // ****************************************
    // register byte addresses and indexes
    // ****************************************
    localparam logic [11:0] REG_BASE = 12'h000;
    localparam logic [11:0] REG_CTRL = 12'h004;
    localparam logic [11:0] REG_STAT = 12'h008;
    localparam logic [11:0] REG_SLOT = 12'h00c;
    localparam logic [11:0] REG_VEC = 12'h010;
    localparam logic [11:0] IDX_SEL_A = 12'h35e;
    localparam logic [11:0] IDX_SEL_B = 12'h35f;
    localparam int CTRL_AMATCH_BIT = 0;
endpackage

// ==== hw/ivg_fetch_if.sv ====
// interface: vector fetch request and answer between control and engine
`timescale 1ns/1ps
interface ivg_fetch_if;
    logic start;
    logic [19:0] addr;
    logic done;
    logic [31:0] word;
    modport ctl (output start, output addr, input done, input word);
    modport eng (input start, input addr, output done, output word);
endinterface

// ==== hw/ivg_slot_calc.sv ====
// module: maps a request onto the address of its vector slot
`timescale 1ns/1ps
module ivg_slot_calc (
    // request
    input wire ivg_pkg::ivg_kind_type kind,
    input wire logic [5:0] num,
    // settings
    input wire logic [19:0] base,
    input wire logic [7:0] sel_a,
    input wire logic [7:0] sel_b,
    // answer
    output logic [19:0] slot,
    output logic ok
);
    logic [5:0] eff;

    // pick the table entry; shared slots follow their select bits
    always_comb begin
        eff = num;
        ok = 1'b1;
        slot = base + {12'h000, num, 2'b00};
        case (kind)
            ivg_pkg::K_FIXED: begin
                ok = (num <= ivg_pkg::FX_LAST);
                slot = ivg_pkg::FIXED_LO + {12'h000, num, 2'b00};
            end
            ivg_pkg::K_SWINT: begin
                slot = base + {12'h000, num, 2'b00};
            end
            ivg_pkg::K_PERIPH: begin
                if (num == ivg_pkg::PID_BUSCOL) begin
                    eff = ivg_pkg::SLOT_TA5;
                    ok = sel_a[ivg_pkg::SEL_A_BIT]; // RQ18
                end else if (num == ivg_pkg::SLOT_TA5) begin
                    ok = !sel_a[ivg_pkg::SEL_A_BIT]; // RQ18
                end else if (num == ivg_pkg::PID_EXT_PIN_IRQ_4) begin
                    eff = ivg_pkg::SLOT_TA3;
                    ok = sel_b[ivg_pkg::SEL_B_TA3_BIT]; // RQ19
                end else if (num == ivg_pkg::SLOT_TA3) begin
                    ok = !sel_b[ivg_pkg::SEL_B_TA3_BIT]; // RQ19
                end else if (num == ivg_pkg::PID_EXT_PIN_IRQ_5) begin
                    eff = ivg_pkg::SLOT_TA4;
                    ok = sel_b[ivg_pkg::SEL_B_TA4_BIT]; // RQ19
                end else if (num == ivg_pkg::SLOT_TA4) begin
                    ok = !sel_b[ivg_pkg::SEL_B_TA4_BIT]; // RQ19
                end else begin
                    ok = (num >= ivg_pkg::PID_FIRST) && (num <= ivg_pkg::PID_LAST); // RQ12
                end
                slot = base + {12'h000, eff, 2'b00}; // RQ12 RQ13 RQ14 RQ15 RQ16
            end
            default: begin
                ok = 1'b0;
            end
        endcase
    end
endmodule

// ==== hw/ivg_fetch_eng.sv ====
// module: reads one four-byte vector, lowest byte first
`timescale 1ns/1ps
module ivg_fetch_eng (
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // control side
    ivg_fetch_if.eng f,
    // memory byte port
    output logic mem_req,
    output logic [19:0] mem_addr,
    input wire logic mem_ack,
    input wire logic [7:0] mem_rdata
);
    typedef struct packed {
        logic req;
        logic [19:0] addr;
        logic [1:0] cnt;
        logic [31:0] word;
        logic done;
    } ivg_eng_state_type;

    ivg_eng_state_type s_r, s_nxt;

    // byte sequencing; bytes shift in from the top so the first lands lowest
    always_comb begin
        s_nxt = s_r;
        s_nxt.done = 1'b0;
        if (!s_r.req && f.start) begin
            s_nxt.req = 1'b1;
            s_nxt.addr = f.addr;
            s_nxt.cnt = 2'h0;
        end else if (s_r.req && mem_ack) begin
            s_nxt.word = {mem_rdata, s_r.word[31:8]}; // RQ22
            if (s_r.cnt == 2'h3) begin
                s_nxt.req = 1'b0;
                s_nxt.done = 1'b1; // RQ2
            end else begin
                s_nxt.cnt = s_r.cnt + 2'h1;
                s_nxt.addr = s_r.addr + 20'h00001;
            end
        end
    end

    // state register
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign mem_req = s_r.req;
    assign mem_addr = s_r.addr;
    assign f.done = s_r.done;
    assign f.word = s_r.word;
endmodule

// ==== testbench/ivg_mem_model.sv ====
// partner model: byte-wide vector memory answering the fetch engine
`timescale 1ns/1ps
module ivg_mem_model (
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // memory byte port
    input wire logic mem_req,
    input wire logic [19:0] mem_addr,
    output logic mem_ack,
    output logic [7:0] mem_rdata,
    // behaviour controls
    input wire logic [3:0] wait_cycles,
    input wire logic brk_erased
);
    // ****************************************
    // contents and answer timing
    // ****************************************
    logic [3:0] cnt_r;

    // every slot holds a routine address built from its own byte addresses; with brk_erased the break slot reads all ones
    function automatic logic [7:0] mem_byte(input logic [19:0] a, input logic erased);
        if (erased && a[19:2] == 18'h3fff9) begin
            return 8'hff;
        end
        return a[7:0] ^ a[15:8] ^ 8'h5a;
    endfunction

    // one ack per byte after a programmable wait; idle data keeps changing
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            mem_ack <= 1'b0;
            cnt_r <= 4'h0;
            mem_rdata <= 8'h00;
        end else if (mem_ack) begin
            mem_ack <= 1'b0;
            cnt_r <= 4'h0;
            mem_rdata <= ~mem_rdata; // no stale byte after the ack
        end else if (mem_req && cnt_r >= wait_cycles) begin
            mem_ack <= 1'b1;
            mem_rdata <= mem_byte(mem_addr, brk_erased);
        end else begin
            cnt_r <= mem_req ? cnt_r + 4'h1 : 4'h0;
            mem_rdata <= ~mem_rdata;
        end
    end
endmodule

// ==== testbench/ivg_top_tb.sv ====
// testbench: vector slot mapping, fetch order and register access
`timescale 1ns/1ps
module ivg_top_tb;
    // ****************************************
    // signals
    // ****************************************
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready, pslverr, req_busy, req_err, vec_valid, mem_req, mem_ack;
    logic req_valid = 1'b0;
    ivg_pkg::ivg_kind_type req_kind = ivg_pkg::K_FIXED;
    logic [5:0] req_num = 6'h00;
    logic i_flag = 1'b0;
    logic [19:0] vec_addr, vec_slot, mem_addr;
    logic [7:0] mem_rdata;
    logic [3:0] wait_cycles = 4'h0;
    logic brk_erased = 1'b0;
    logic [19:0] base = 20'h12340;
    logic [31:0] rd;
    logic err;
    int errors = 0;
    int num_checks = 0;

    ivg_top ivg_top_i (.sys_clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .req_valid, .req_kind, .req_num, .i_flag, .req_busy, .req_err, .vec_valid, .vec_addr,
        .vec_slot, .mem_req, .mem_addr, .mem_ack, .mem_rdata);
    ivg_mem_model ivg_mem_model_i (.sys_clk, .nrst, .mem_req, .mem_addr, .mem_ack, .mem_rdata,
        .wait_cycles, .brk_erased);

    // 10 mhz clock
    always #50 sys_clk = ~sys_clk;

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic wrap_up();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // a wait that runs out ends the run
    task automatic hang();
        check(32'h0, 32'h1);
        wrap_up();
    endtask

    // expected memory byte, same layout the partner holds
    function automatic logic [7:0] mb(input logic [19:0] a);
        if (brk_erased && a[19:2] == 18'h3fff9) begin
            return 8'hff;
        end
        return a[7:0] ^ a[15:8] ^ 8'h5a;
    endfunction

    // low byte first, twenty bits kept
    function automatic logic [19:0] vec_of(input logic [19:0] s);
        logic [31:0] w;
        w = {mb(s + 20'h3), mb(s + 20'h2), mb(s + 20'h1), mb(s)};
        return w[19:0];
    endfunction

    // one apb transfer, held until pready
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            hang();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // one request, then wait for refusal or vector
    task automatic req(input ivg_pkg::ivg_kind_type k, input logic [5:0] n, output int c, output logic ok);
        @(posedge sys_clk);
        req_valid <= 1'b1;
        req_kind <= k;
        req_num <= n;
        @(posedge sys_clk);
        req_valid <= 1'b0;
        ok = 1'b0;
        for (c = 0; c < 300; c++) begin
            @(posedge sys_clk);
            if (req_err === 1'b1) begin
                break;
            end
            if (vec_valid === 1'b1) begin
                ok = 1'b1;
                break;
            end
        end
        if (c >= 300) begin
            hang();
        end
    endtask

    task automatic want_vec(input ivg_pkg::ivg_kind_type k, input logic [5:0] n, input logic [19:0] s);
        int c;
        logic ok;
        req(k, n, c, ok);
        check({31'h0, ok}, 32'h1);
        check({12'h0, vec_slot}, {12'h0, s});
        check({12'h0, vec_addr}, {12'h0, vec_of(s)});
    endtask

    task automatic want_ref(input ivg_pkg::ivg_kind_type k, input logic [5:0] n);
        int c;
        logic ok;
        req(k, n, c, ok);
        check({31'h0, ok}, 32'h0);
        check(32'(c), 32'h0);
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    // reset value of base, unmapped access, base write and readback
    task automatic t_regs();
        apb(1'b0, ivg_pkg::REG_BASE, 32'h0);
        check(rd, 32'h0);
        apb(1'b1, 12'h020, 32'hffffffff);
        check({31'h0, err}, 32'h1);
        apb(1'b1, ivg_pkg::REG_BASE, {12'h0, base});
        apb(1'b0, ivg_pkg::REG_BASE, 32'h0);
        check(rd, {12'h0, base});
    endtask

    // fixed slots stay put with the base moved to 12340; debug-only slots left alone
    task automatic t_fixed();
        logic [5:0] idx [6] = '{ivg_pkg::FX_UND, ivg_pkg::FX_OVF, ivg_pkg::FX_BRK, ivg_pkg::FX_WDT,
            ivg_pkg::FX_NMI, ivg_pkg::FX_LAST};
        logic [19:0] adr [6] = '{ivg_pkg::VEC_UND, ivg_pkg::VEC_OVF, ivg_pkg::VEC_BRK, ivg_pkg::VEC_WDT,
            ivg_pkg::VEC_NMI, ivg_pkg::VEC_RST};
        want_ref(ivg_pkg::K_FIXED, ivg_pkg::FX_AMATCH);
        want_ref(ivg_pkg::K_FIXED, 6'h09);
        apb(1'b1, ivg_pkg::REG_CTRL, 32'h1);
        want_vec(ivg_pkg::K_FIXED, ivg_pkg::FX_AMATCH, ivg_pkg::VEC_AMATCH);
        for (int i = 0; i < 6; i++) begin
            want_vec(ivg_pkg::K_FIXED, idx[i], adr[i]);
        end
    endtask

    // software numbers ignore the global enable, boundaries 0, 31, 32, 63
    task automatic t_swint();
        logic [5:0] nums [6] = '{6'h00, 6'h0a, 6'h18, 6'h1f, 6'h20, 6'h3f};
        i_flag <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            want_vec(ivg_pkg::K_SWINT, nums[i], base + {12'h0, nums[i], 2'b00});
        end
    endtask

    // every peripheral slot, masking, and the shared slot selects
    task automatic t_periph();
        want_ref(ivg_pkg::K_PERIPH, 6'h04);
        i_flag <= 1'b1;
        for (int n = 4; n < 32; n++) begin
            want_vec(ivg_pkg::K_PERIPH, 6'(n), base + {12'h0, 6'(n), 2'b00});
        end
        for (int n = 0; n < 4; n++) begin
            want_ref(ivg_pkg::K_PERIPH, 6'(n));
        end
        apb(1'b1, 12'hd78, 32'h10);
        apb(1'b1, 12'hd7c, 32'hc0);
        want_vec(ivg_pkg::K_PERIPH, ivg_pkg::PID_BUSCOL, base + 20'h28);
        want_vec(ivg_pkg::K_PERIPH, ivg_pkg::PID_EXT_PIN_IRQ_4, base + 20'h60);
        want_vec(ivg_pkg::K_PERIPH, ivg_pkg::PID_EXT_PIN_IRQ_5, base + 20'h64);
        want_ref(ivg_pkg::K_PERIPH, ivg_pkg::SLOT_TA5);
        want_ref(ivg_pkg::K_PERIPH, ivg_pkg::SLOT_TA3);
        want_ref(ivg_pkg::K_PERIPH, ivg_pkg::SLOT_TA4);
    endtask

    // break with slow memory, then an erased break slot falls back to table slot 0
    task automatic t_brk();
        wait_cycles <= 4'h3;
        want_vec(ivg_pkg::K_FIXED, ivg_pkg::FX_BRK, ivg_pkg::VEC_BRK);
        brk_erased <= 1'b1;
        i_flag <= 1'b0;
        want_vec(ivg_pkg::K_FIXED, ivg_pkg::FX_BRK, base);
        // the readable copies of the last slot and vector follow the fallback
        apb(1'b0, ivg_pkg::REG_SLOT, 32'h0);
        check(rd, {12'h0, base});
        apb(1'b0, ivg_pkg::REG_VEC, 32'h0);
        check(rd, {12'h0, vec_of(base)});
        apb(1'b0, ivg_pkg::REG_STAT, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, ivg_pkg::REG_CTRL, 32'h0);
        check(rd, 32'h1);
        check({31'h0, err}, 32'h0);
        brk_erased <= 1'b0;
        wait_cycles <= 4'h0;
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        repeat (8) @(posedge sys_clk);
        nrst <= 1'b1;
        t_regs();
        t_fixed();
        t_swint();
        t_periph();
        t_brk();
        wrap_up();
    end
endmodule
